// ===== mps_settings.sv
// motion parameter settings store with frame write/read and input polarity
`timescale 1ns/100ps
`default_nettype none
module mps_settings (
   // clock and control
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // received frame, one-cycle strobe once fully checked
   input  wire logic        frame_valid,
   input  wire logic        frame_write,
   input  wire logic [7:0]  frame_cmd,
   input  wire logic [7:0]  frame_op,
   input  wire logic [31:0] frame_data,
   // read answer
   output logic             rd_valid,
   output logic             rd_ok,
   output logic [31:0]      rd_data,
   // operation selected by motion logic
   input  wire logic [5:0]  run_op,
   output logic             run_seq_en,
   output logic             run_fixed_target_travel,
   output logic [1:0]       run_mode,
   // dwell between chained motions
   input  wire logic        dwell_start,
   output logic             dwell_busy,
   output logic             dwell_done,
   output logic [15:0]      dwell_remaining,
   // global settings
   output logic             home_search_sensor_count,
   output logic [1:0]       stop_input_action,
   output logic             overtravel_stop_action,
   // raw contacts, high when contact closed
   input  wire logic        limit_switch_inputs_pos,
   input  wire logic        limit_switch_inputs_neg,
   input  wire logic        origin_sensor_input,
   input  wire logic        index_slot_input,
   input  wire logic        stop_input,
   input  wire logic        all_windings_off_input,
   // qualified inputs to motion logic
   output logic             limit_pos_active,
   output logic             limit_neg_active,
   output logic             origin_active,
   output logic             index_slot_active,
   output logic             stop_active,
   output logic             windings_off_active
);
   // ==========================================================
   // storage
   // ==========================================================
   logic [mps_pkg::NUM_OPS-1:0]  sequential_positioning_enable;
   logic [mps_pkg::NUM_OPS-1:0]  positioning_target_mode;
   logic [1:0]                   motion_linking_mode [mps_pkg::NUM_OPS];
   logic [mps_pkg::DWELL_W-1:0]  dwell_time [mps_pkg::NUM_OPS];
   logic                         limit_switch_polarity;
   logic                         origin_sensor_polarity;
   logic                         index_slot_polarity;
   logic                         stop_input_polarity;
   logic                         windings_off_polarity;

   // ==========================================================
   // decode
   // ==========================================================
   wire [mps_pkg::OP_W-1:0] op_idx = frame_op[mps_pkg::OP_W-1:0];
   wire op_per  = (frame_op >= mps_pkg::OP_FIRST) &&
                  (frame_op <= mps_pkg::OP_LAST);
   wire op_glob = (frame_op == mps_pkg::OP_GLOBAL);
   wire wr      = frame_valid && frame_write;

   // range checks
   wire fits_bit   = (frame_data <= mps_pkg::MAX_BIT);
   wire fits_opm   = (frame_data <= mps_pkg::MAX_OPMODE);
   wire fits_stop  = (frame_data <= mps_pkg::MAX_STOP);
   wire fits_dwell = (frame_data <= mps_pkg::MAX_DWELL);

   wire is_seq   = (frame_cmd == mps_pkg::CMD_SEQ_EN);
   wire is_pos   = (frame_cmd == mps_pkg::CMD_POS_MODE);
   wire is_opm   = (frame_cmd == mps_pkg::CMD_OP_MODE);
   wire is_dwell = (frame_cmd == mps_pkg::CMD_DWELL);
   wire is_home  = (frame_cmd == mps_pkg::CMD_HOME_CNT);
   wire is_stopa = (frame_cmd == mps_pkg::CMD_STOP_ACT);
   wire is_ot    = (frame_cmd == mps_pkg::CMD_OT_ACT);
   wire is_lsp   = (frame_cmd == mps_pkg::CMD_LS_POL);
   wire is_hp    = (frame_cmd == mps_pkg::CMD_HOME_POL);
   wire is_sp    = (frame_cmd == mps_pkg::CMD_INDEX_SLOT_INPUT_POL);
   wire is_stp   = (frame_cmd == mps_pkg::CMD_STOP_POL);
   wire is_awp   = (frame_cmd == mps_pkg::CMD_AWO_POL);

   wire per_cmd  = is_seq | is_pos | is_opm | is_dwell;
   wire glob_cmd = is_home | is_stopa | is_ot | is_lsp | is_hp |
                   is_sp | is_stp | is_awp;
   wire addr_ok  = (per_cmd & op_per) | (glob_cmd & op_glob);

   wire range_ok = ((is_seq | is_pos | is_home | is_ot | is_lsp |
                     is_hp | is_sp | is_stp | is_awp) & fits_bit) |
                   (is_opm & fits_opm) | (is_stopa & fits_stop) |
                   (is_dwell & fits_dwell);

   wire wr_en   = wr && addr_ok && range_ok;
   wire bit_val = frame_data[0];

   // ==========================================================
   // readback
   // ==========================================================
   logic [31:0] next_rd_data;
   always_comb begin
      next_rd_data = '0;
      case (1'b1)
         is_seq:   next_rd_data[0] = sequential_positioning_enable[op_idx];
         is_pos:   next_rd_data[0] = positioning_target_mode[op_idx];
         is_opm:   next_rd_data[1:0] = motion_linking_mode[op_idx];
         is_dwell: next_rd_data[15:0] = dwell_time[op_idx];
         is_home:  next_rd_data[0] = home_search_sensor_count;
         is_stopa: next_rd_data[1:0] = stop_input_action;
         is_ot:    next_rd_data[0] = overtravel_stop_action;
         is_lsp:   next_rd_data[0] = limit_switch_polarity;
         is_hp:    next_rd_data[0] = origin_sensor_polarity;
         is_sp:    next_rd_data[0] = index_slot_polarity;
         is_stp:   next_rd_data[0] = stop_input_polarity;
         is_awp:   next_rd_data[0] = windings_off_polarity;
         default:  next_rd_data = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_ok    <= 1'b0;
         rd_data  <= '0;
      end else if (ce) begin
         rd_valid <= frame_valid && !frame_write;
         rd_ok    <= addr_ok;
         rd_data  <= (frame_valid && !frame_write && addr_ok)
                     ? next_rd_data : '0;
      end
   end

   // ==========================================================
   // per-operation store
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (rst) begin
         sequential_positioning_enable <= {mps_pkg::NUM_OPS{
                                            mps_pkg::RST_SEQ_EN}};
         positioning_target_mode <= {mps_pkg::NUM_OPS{
                                      mps_pkg::RST_POS_MODE}};
         for (int i = 0; i < mps_pkg::NUM_OPS; i++) begin
            motion_linking_mode[i] <= mps_pkg::RST_OP_MODE;
            dwell_time[i] <= mps_pkg::RST_DWELL;
         end
      end else if (ce && wr_en) begin
         if (is_seq) sequential_positioning_enable[op_idx] <= bit_val;
         if (is_pos) positioning_target_mode[op_idx] <= bit_val;
         if (is_opm) motion_linking_mode[op_idx] <= frame_data[1:0];
         if (is_dwell) dwell_time[op_idx] <= frame_data[15:0];
      end
   end

   // ==========================================================
   // global store
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (rst) begin
         home_search_sensor_count <= mps_pkg::RST_HOME_CNT;
         stop_input_action        <= mps_pkg::RST_STOP_ACT;
         overtravel_stop_action   <= mps_pkg::RST_OT_ACT;
         limit_switch_polarity    <= mps_pkg::RST_LS_POL;
         origin_sensor_polarity   <= mps_pkg::RST_HOME_POL;
         index_slot_polarity      <= mps_pkg::RST_INDEX_SLOT_INPUT_POL;
         stop_input_polarity      <= mps_pkg::RST_STOP_POL;
         windings_off_polarity    <= mps_pkg::RST_AWO_POL;
      end else if (ce && wr_en) begin
         if (is_home)  home_search_sensor_count <= bit_val;
         if (is_stopa) stop_input_action <= frame_data[1:0];
         if (is_ot)    overtravel_stop_action <= bit_val;
         if (is_lsp)   limit_switch_polarity <= bit_val;
         if (is_hp)    origin_sensor_polarity <= bit_val;
         if (is_sp)    index_slot_polarity <= bit_val;
         if (is_stp)   stop_input_polarity <= bit_val;
         if (is_awp)   windings_off_polarity <= bit_val;
      end
   end

   // ==========================================================
   // selected operation outputs
   // ==========================================================
   // motion samples the op entry; host must not rewrite it mid-move
   always_ff @(posedge mclk) begin
      if (rst) begin
         run_seq_en              <= mps_pkg::RST_SEQ_EN;
         run_fixed_target_travel <= mps_pkg::RST_POS_MODE;
         run_mode                <= mps_pkg::RST_OP_MODE;
      end else if (ce) begin
         run_seq_en              <= sequential_positioning_enable[run_op];
         run_fixed_target_travel <= positioning_target_mode[run_op];
         run_mode                <= motion_linking_mode[run_op];
      end
   end

   // ==========================================================
   // dwell between chained motions
   // ==========================================================
   // dwell only in chained mode
   wire dwell_go = dwell_start &&
                   (motion_linking_mode[run_op] ==
                    mps_pkg::OPM_CHAINED_WITH_DWELL);

   mps_dwell u_dwell (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .start     (dwell_go),
      .dwell_ms  (dwell_time[run_op]),
      .busy      (dwell_busy),
      .done      (dwell_done),
      .remaining (dwell_remaining)
   );

   // ==========================================================
   // contact qualification
   // ==========================================================
   // polarity applied per sensor, both limit switch inputs sharing limit_switch_polarity
   mps_contact u_lsp (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (limit_switch_inputs_pos),
      .normally_closed (limit_switch_polarity),
      .active          (limit_pos_active)
   );
   mps_contact u_lsn (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (limit_switch_inputs_neg),
      .normally_closed (limit_switch_polarity),
      .active          (limit_neg_active)
   );
   mps_contact u_org (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (origin_sensor_input),
      .normally_closed (origin_sensor_polarity),
      .active          (origin_active)
   );
   mps_contact u_slt (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (index_slot_input),
      .normally_closed (index_slot_polarity),
      .active          (index_slot_active)
   );
   mps_contact u_stp (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (stop_input),
      .normally_closed (stop_input_polarity),
      .active          (stop_active)
   );
   mps_contact u_awo (
      .mclk (mclk), .rst (rst), .ce (ce),
      .contact_closed  (all_windings_off_input),
      .normally_closed (windings_off_polarity),
      .active          (windings_off_active)
   );
endmodule : mps_settings
`default_nettype wire

// ===== mps_pkg.sv
// package: command codes, field layouts, reset values and timing for settings
package mps_pkg;
   // command codes carried by a received frame
   localparam logic [7:0] CMD_DWELL    = 8'h0e;
   localparam logic [7:0] CMD_SEQ_EN   = 8'h0f;
   localparam logic [7:0] CMD_POS_MODE = 8'h10;
   localparam logic [7:0] CMD_OP_MODE  = 8'h11;
   localparam logic [7:0] CMD_HOME_CNT = 8'h12;
   localparam logic [7:0] CMD_STOP_ACT = 8'h13;
   localparam logic [7:0] CMD_OT_ACT   = 8'h14;
   localparam logic [7:0] CMD_LS_POL   = 8'h1a;
   localparam logic [7:0] CMD_HOME_POL = 8'h1b;
   localparam logic [7:0] CMD_INDEX_SLOT_INPUT_POL = 8'h1c;
   localparam logic [7:0] CMD_STOP_POL = 8'h1d;
   localparam logic [7:0] CMD_AWO_POL  = 8'h1e;

   // operation data numbers
   localparam int          NUM_OPS    = 64;
   localparam logic [7:0]  OP_GLOBAL  = 8'h00;
   localparam logic [7:0]  OP_FIRST   = 8'h01;
   localparam logic [7:0]  OP_LAST    = 8'h3f;
   localparam int          OP_W       = 6;

   // legal maxima of each setting
   localparam logic [31:0] MAX_BIT    = 32'h0000_0001;
   localparam logic [31:0] MAX_OPMODE = 32'h0000_0002;
   localparam logic [31:0] MAX_STOP   = 32'h0000_0003;
   localparam logic [31:0] MAX_DWELL  = 32'h0000_c350;
   localparam int          DWELL_W    = 16;

   // reset values
   localparam logic        RST_SEQ_EN   = 1'b0;
   localparam logic        RST_POS_MODE = 1'b0;
   localparam logic [1:0]  RST_OP_MODE  = 2'h0;
   localparam logic        RST_HOME_CNT = 1'b1;
   localparam logic [1:0]  RST_STOP_ACT = 2'h1;
   localparam logic        RST_OT_ACT   = 1'b0;
   localparam logic        RST_LS_POL   = 1'b0;
   localparam logic        RST_HOME_POL = 1'b0;
   localparam logic        RST_INDEX_SLOT_INPUT_POL = 1'b0;
   localparam logic        RST_STOP_POL = 1'b1;
   localparam logic        RST_AWO_POL  = 1'b0;
   localparam logic [DWELL_W-1:0] RST_DWELL = 16'h0000;

   // operating mode encodings
   localparam logic [1:0] OPM_SINGLE  = 2'h0;
   localparam logic [1:0] OPM_LINK    = 2'h1;
   localparam logic [1:0] OPM_CHAINED_WITH_DWELL = 2'h2;

   // dwell timing: 1 ms units at 50 MHz
   localparam int CLK_HZ        = 50_000_000;
   localparam int DWELL_UNIT_US = 1000;
   localparam int TICK_CYC      = (CLK_HZ / 1_000_000) * DWELL_UNIT_US;
   localparam int TICK_W        = 16;

   // dwell sequencer states, gray along idle->count->done
   typedef enum logic [1:0] {
      MPS_IDLE  = 2'b00,
      MPS_COUNT = 2'b01,
      MPS_DONE  = 2'b11
   } mps_dwell_e;
endpackage : mps_pkg

// ===== mps_contact.sv
// contact polarity converter for one sensor input
`timescale 1ns/100ps
`default_nettype none
module mps_contact (
   // clock
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // contact
   input  wire logic contact_closed,
   input  wire logic normally_closed,
   // result
   output logic      active
);
   // normally-open active when closed, normally-closed when open
   wire next_active = contact_closed ^ normally_closed;

   always_ff @(posedge mclk) begin
      if (rst) begin
         active <= 1'b0;
      end else if (ce) begin
         active <= next_active;
      end
   end
endmodule : mps_contact
`default_nettype wire

// ===== mps_dwell.sv
// dwell timer between chained motions, counts 1 ms ticks
`timescale 1ns/100ps
`default_nettype none
module mps_dwell (
   // clock
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   // request
   input  wire logic                        start,
   input  wire logic [mps_pkg::DWELL_W-1:0] dwell_ms,
   // status
   output logic                             busy,
   output logic                             done,
   output logic [mps_pkg::DWELL_W-1:0]      remaining
);
   localparam logic [mps_pkg::TICK_W-1:0] TICK_LAST =
      mps_pkg::TICK_W'(mps_pkg::TICK_CYC - 1);

   mps_pkg::mps_dwell_e             state;
   logic [mps_pkg::TICK_W-1:0]      tick_cnt;

   wire tick_end  = (tick_cnt == TICK_LAST);
   wire last_ms   = (remaining == mps_pkg::DWELL_W'(1));
   wire zero_ms   = (dwell_ms == '0);

   assign busy = (state == mps_pkg::MPS_COUNT);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state     <= mps_pkg::MPS_IDLE;
         tick_cnt  <= '0;
         remaining <= '0;
         done      <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         case (state)
            mps_pkg::MPS_IDLE: begin
               tick_cnt  <= '0;
               if (start) begin
                  remaining <= dwell_ms;
                  // zero dwell passes straight through
                  state     <= zero_ms ? mps_pkg::MPS_DONE
                                       : mps_pkg::MPS_COUNT;
               end
            end
            mps_pkg::MPS_COUNT: begin
               tick_cnt <= tick_end ? '0 : tick_cnt + 1'b1;
               if (tick_end) begin
                  remaining <= remaining - 1'b1;
                  if (last_ms) begin
                     state <= mps_pkg::MPS_DONE;
                  end
               end
            end
            mps_pkg::MPS_DONE: begin
               done  <= 1'b1;
               state <= mps_pkg::MPS_IDLE;
            end
            default: state <= mps_pkg::MPS_IDLE;
         endcase
      end
   end
endmodule : mps_dwell
`default_nettype wire

// ===== mps_settings_sva.sv
// checker: timing relations at the settings store ports
`timescale 1ns/100ps
`default_nettype none
module mps_settings_sva (
   // clock
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   // frame
   input wire logic        frame_valid,
   input wire logic        frame_write,
   input wire logic [7:0]  frame_cmd,
   input wire logic [7:0]  frame_op,
   input wire logic [31:0] frame_data,
   // answers and settings
   input wire logic        rd_valid,
   input wire logic        rd_ok,
   input wire logic [31:0] rd_data,
   input wire logic        dwell_done,
   input wire logic [1:0]  stop_input_action,
   input wire logic        overtravel_stop_action,
   input wire logic        limit_switch_inputs_pos,
   input wire logic        limit_pos_active
);
   // ==========================================
   // frame sequences
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic ls_wr;
   assign ls_wr = frame_valid && frame_write
                  && frame_cmd == mps_pkg::CMD_LS_POL;
   sequence s_rd;
      ce && frame_valid && !frame_write;
   endsequence
   sequence s_glob(c);
      ce && frame_valid && frame_write && frame_cmd == c
      && frame_op == 8'h00;
   endsequence
   // ==========================================
   // assertions
   a_read_answer: assert property (s_rd |=> rd_valid)
      else $error("read frame got no answer");
   a_no_stray: assert property (
      ce && !(frame_valid && !frame_write) |=> !rd_valid)
      else $error("answer without read frame");
   a_refused_zero: assert property (
      rd_valid && !rd_ok |-> rd_data == 32'h0000_0000)
      else $error("refused read carries data");
   a_stop_write: assert property (
      s_glob(mps_pkg::CMD_STOP_ACT) ##0 frame_data <= mps_pkg::MAX_STOP
      |=> stop_input_action == $past(frame_data[1:0]))
      else $error("stop action not written");
   a_ot_range: assert property (
      s_glob(mps_pkg::CMD_OT_ACT) ##0 frame_data > mps_pkg::MAX_BIT
      |=> $stable(overtravel_stop_action))
      else $error("out of range overtravel write applied");
   a_stop_hold: assert property (
      !(frame_valid && frame_write
        && frame_cmd == mps_pkg::CMD_STOP_ACT)
      |=> $stable(stop_input_action))
      else $error("stop action changed without write");
   a_limit_follow: assert property (
      !$past(rst) && !$past(ls_wr) && ce
      && limit_switch_inputs_pos != $past(limit_switch_inputs_pos)
      |=> limit_pos_active != $past(limit_pos_active))
      else $error("limit active did not follow contact");
   a_done_pulse: assert property (dwell_done |=> !dwell_done)
      else $error("dwell done longer than one cycle");
endmodule : mps_settings_sva
bind mps_settings mps_settings_sva chk_u (
   .mclk(mclk), .rst(rst), .ce(ce), .frame_valid(frame_valid),
   .frame_write(frame_write), .frame_cmd(frame_cmd),
   .frame_op(frame_op), .frame_data(frame_data), .rd_valid(rd_valid),
   .rd_ok(rd_ok), .rd_data(rd_data), .dwell_done(dwell_done),
   .stop_input_action(stop_input_action),
   .overtravel_stop_action(overtravel_stop_action),
   .limit_switch_inputs_pos(limit_switch_inputs_pos),
   .limit_pos_active(limit_pos_active));
`default_nettype wire

// ===== mps_host.sv
// host model: issues checked command frames one word at a time
`timescale 1ns/100ps
`default_nettype none
module mps_host (
   // clock
   input  wire logic  mclk,
   // frame
   output var logic        frame_valid,
   output var logic        frame_write,
   output var logic [7:0]  frame_cmd,
   output var logic [7:0]  frame_op,
   output var logic [31:0] frame_data
);
   initial begin
      frame_valid = 1'b0;
      frame_write = 1'b0;
      frame_cmd   = 8'h00;
      frame_op    = 8'h00;
      frame_data  = 32'h0000_0000;
   end
   // one frame per call, sent whether or not a dwell is running
   task automatic xfer(input logic w, input logic [7:0] c, o,
                       input logic [31:0] d);
      @(posedge mclk);
      frame_valid <= 1'b1;
      frame_write <= w;
      frame_cmd   <= c;
      frame_op    <= o;
      frame_data  <= d;
      @(posedge mclk);
      // released lines show garbage so stale values are never trusted
      frame_valid <= 1'b0;
      frame_write <= ~w;
      frame_cmd   <= ~c;
      frame_op    <= ~o;
      frame_data  <= ~d;
   endtask : xfer
endmodule : mps_host
`default_nettype wire

// ===== mps_settings_bench.sv
// testbench: settings store driven by the host model, scoreboarded reads
`timescale 1ns/100ps
`default_nettype none
module mps_settings_bench;
   // ==========================================
   // signals
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, dwell_start = 1'b0;
   logic frame_valid, frame_write, rd_valid, rd_ok;
   logic [7:0]  frame_cmd, frame_op;
   logic [31:0] frame_data, rd_data, seed;
   logic [5:0]  run_op = 6'h00, cont = 6'h00, act;
   logic        run_seq_en, run_ftt, busy, done, home, ot;
   logic [1:0]  run_mode, stop_act;
   logic [15:0] remaining;
   logic [32:0] expq[$];
   int n_fail = 0, checks_done = 0;
   localparam logic [7:0] CMDS [12] = '{mps_pkg::CMD_DWELL,
      mps_pkg::CMD_SEQ_EN, mps_pkg::CMD_POS_MODE, mps_pkg::CMD_OP_MODE,
      mps_pkg::CMD_HOME_CNT, mps_pkg::CMD_STOP_ACT, mps_pkg::CMD_OT_ACT,
      mps_pkg::CMD_LS_POL, mps_pkg::CMD_HOME_POL, mps_pkg::CMD_INDEX_SLOT_INPUT_POL,
      mps_pkg::CMD_STOP_POL, mps_pkg::CMD_AWO_POL};
   localparam logic [31:0] MAXV [12] = '{mps_pkg::MAX_DWELL,
      mps_pkg::MAX_BIT, mps_pkg::MAX_BIT, mps_pkg::MAX_OPMODE,
      mps_pkg::MAX_BIT, mps_pkg::MAX_STOP, mps_pkg::MAX_BIT,
      mps_pkg::MAX_BIT, mps_pkg::MAX_BIT, mps_pkg::MAX_BIT,
      mps_pkg::MAX_BIT, mps_pkg::MAX_BIT};
   localparam logic [11:0] RSTV = 12'b0000_1100_0010;
   always #10 mclk = ~mclk;
   mps_host host_u (.mclk(mclk), .frame_valid(frame_valid),
      .frame_write(frame_write), .frame_cmd(frame_cmd),
      .frame_op(frame_op), .frame_data(frame_data));
   mps_settings dut_u (.mclk(mclk), .rst(rst), .ce(ce),
      .frame_valid(frame_valid), .frame_write(frame_write),
      .frame_cmd(frame_cmd), .frame_op(frame_op),
      .frame_data(frame_data), .rd_valid(rd_valid), .rd_ok(rd_ok),
      .rd_data(rd_data), .run_op(run_op), .run_seq_en(run_seq_en),
      .run_fixed_target_travel(run_ftt), .run_mode(run_mode),
      .dwell_start(dwell_start), .dwell_busy(busy), .dwell_done(done),
      .dwell_remaining(remaining), .home_search_sensor_count(home),
      .stop_input_action(stop_act), .overtravel_stop_action(ot),
      .limit_switch_inputs_pos(cont[5]), .limit_switch_inputs_neg(cont[4]),
      .origin_sensor_input(cont[3]), .index_slot_input(cont[2]),
      .stop_input(cont[1]), .all_windings_off_input(cont[0]),
      .limit_pos_active(act[5]), .limit_neg_active(act[4]),
      .origin_active(act[3]), .index_slot_active(act[2]),
      .stop_active(act[1]), .windings_off_active(act[0]));
   // ==========================================
   // tasks
   task automatic chk(input string what, input logic [32:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] c, o, input logic [31:0] d);
      host_u.xfer(1'b1, c, o, d);
   endtask : wr
   task automatic rd(input logic [7:0] c, o, input logic [32:0] e);
      expq.push_back(e);
      host_u.xfer(1'b0, c, o, 32'h0000_0000);
   endtask : rd
   task automatic dwell(input logic [5:0] o, input int lim, logic e);
      int n;
      @(posedge mclk);
      run_op <= o;
      repeat (3) @(posedge mclk);
      dwell_start <= 1'b1;
      @(posedge mclk);
      dwell_start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < lim) begin
         @(negedge mclk);
         n++;
      end
      chk("dwell_done", done, e);
   endtask : dwell
   task automatic conclude();
      // a read that never got its answer is a failure too
      chk("rd_pending", 33'(expq.size()), 33'h0);
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   // ==========================================
   // read answer scoreboard
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0)
            chk("rd_extra", 33'h0, 33'h1);
         else
            chk("rd_answer", {rd_ok, rd_data}, expq.pop_front());
      end
   end
   initial begin
      #1_500_000;
      n_fail++;
      conclude();
   end
   // ==========================================
   // main sequence
   initial begin
      logic [7:0] o;
      logic [1:0] v;
      seed = 32'h8b4dbf52;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      // qualified contacts need one enabled edge after reset
      @(posedge mclk);
      @(negedge mclk);
      chk("defaults", {home, stop_act, ot, act}, 10'h282);
      for (int i = 0; i < 12; i++) begin
         o = (i < 4) ? 8'h3f : 8'h00;
         rd(CMDS[i], o, {1'b1, 31'h0, RSTV[11-i]});
         wr(CMDS[i], o, MAXV[i]);
         rd(CMDS[i], o, {1'b1, MAXV[i]});
         wr(CMDS[i], o, MAXV[i] + 32'h1);
         rd(CMDS[i], o, {1'b1, MAXV[i]});
      end
      rd(mps_pkg::CMD_SEQ_EN, 8'h00, 33'h0);
      rd(mps_pkg::CMD_STOP_ACT, 8'h01, 33'h0);
      rd(8'h15, 8'h00, 33'h0);
      $display("test register map done");
      for (int k = 0; k < 4; k++) begin
         wr(mps_pkg::CMD_STOP_ACT, 8'h00, k);
         @(negedge mclk);
         chk("stop_action", stop_act, k);
      end
      wr(mps_pkg::CMD_HOME_CNT, 8'h00, 32'h0);
      wr(mps_pkg::CMD_OT_ACT, 8'h00, 32'h0);
      @(negedge mclk);
      chk("home_ot", {home, ot}, 2'h0);
      wr(mps_pkg::CMD_SEQ_EN, 8'h09, 32'h1);
      wr(mps_pkg::CMD_POS_MODE, 8'h09, 32'h1);
      run_op <= 6'h09;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("run_flags", {run_seq_en, run_ftt}, 2'h3);
      repeat (8) begin
         o = 8'h01 + 8'($unsigned($random(seed)) % 63);
         v = 2'($unsigned($random(seed)) % 3);
         wr(mps_pkg::CMD_OP_MODE, o, v);
         run_op <= o[5:0];
         rd(mps_pkg::CMD_OP_MODE, o, {31'h40000000, v});
         @(negedge mclk);
         chk("run_mode", run_mode, v);
      end
      $display("test per operation done");
      for (int k = 7; k < 12; k++)
         wr(CMDS[k], 8'h00, 32'h1);
      repeat (16) begin
         @(posedge mclk);
         cont <= 6'($random(seed));
         @(posedge mclk);
         @(negedge mclk);
         chk("contacts", act, 6'(~cont));
      end
      $display("test contacts done");
      wr(mps_pkg::CMD_OP_MODE, 8'h05, 32'h2);
      wr(mps_pkg::CMD_DWELL, 8'h05, 32'h0);
      wr(mps_pkg::CMD_OP_MODE, 8'h06, 32'h2);
      wr(mps_pkg::CMD_DWELL, 8'h06, 32'h1);
      wr(mps_pkg::CMD_OP_MODE, 8'h07, 32'h1);
      dwell(6'h07, 6, 1'b0);
      dwell(6'h05, 6, 1'b1);
      @(posedge mclk);
      run_op <= 6'h06;
      repeat (3) @(posedge mclk);
      dwell_start <= 1'b1;
      @(posedge mclk);
      dwell_start <= 1'b0;
      @(negedge mclk);
      chk("dwell_run", {busy, remaining}, 17'h10001);
      dwell(6'h06, 50010, 1'b1);
      $display("test dwell done");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("reset_again", stop_act, 2'h1);
      rd(mps_pkg::CMD_SEQ_EN, 8'h09, 33'h100000000);
      repeat (4) @(posedge mclk);
      $display("test second reset done");
      conclude();
   end
endmodule : mps_settings_bench
`default_nettype wire
